// ---- design/asq_pkg.sv ----
// package of the scan sequencer: register map, field layout, timing
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus
package asq_pkg;

    // ----------------------------------------------------------------
    // clock and bus
    // ----------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 10;
    localparam int          AXI_ADDR_W    = 6;
    localparam int          AXI_DATA_W    = 32;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [3:0]  IDX_CONTROL      = 4'h0;
    localparam logic [3:0]  IDX_RESULT_FIRST = 4'h1;
    localparam logic [3:0]  IDX_RESULT_LAST  = 4'h8;
    localparam logic [3:0]  IDX_STATUS       = 4'h9;

    // ----------------------------------------------------------------
    // control register fields
    // ----------------------------------------------------------------
    localparam int          CFG_GO_BIT    = 0;  // conversion_go
    localparam int          CFG_CONT_BIT  = 1;  // continuous_select
    localparam int          CFG_BIAS_BIT  = 2;  // analog_bias_enable
    localparam int          CFG_MULTI_BIT = 3;  // multi_channel_select
    localparam int          CFG_HALVE_BIT = 4;  // converter clock halving
    localparam int          CFG_LAST_LSB  = 5;  // last_channel low bit
    localparam int          CFG_LAST_MSB  = 7;  // last_channel high bit
    localparam logic [7:0]  CFG_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // status register fields
    // ----------------------------------------------------------------
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_CHAN_LSB   = 1;
    localparam int          STAT_CHAN_MSB   = 3;
    localparam int          STAT_SETTLE_BIT = 4;
    localparam int          STAT_WAIT_BIT   = 5;

    // ----------------------------------------------------------------
    // conversion timing in converter clock ticks
    // ----------------------------------------------------------------
    localparam int          CONV_TICKS   = 82;
    localparam int          RESULT_BITS  = 8;
    localparam int          BIT_TICKS    = 4;
    localparam int          SAMPLE_TICKS = CONV_TICKS - RESULT_BITS * BIT_TICKS;
    localparam logic [6:0]  CONV_LAST    = 7'(CONV_TICKS - 1);
    localparam logic [6:0]  SAMPLE_LAST  = 7'(SAMPLE_TICKS - 1);
    localparam logic [1:0]  BIT_LAST     = 2'(BIT_TICKS - 1);
    localparam logic [7:0]  CODE_MSB     = 8'h80;

    // ----------------------------------------------------------------
    // start-up delay after halt ends
    // ----------------------------------------------------------------
    localparam int          STARTUP_US  = 60;
    localparam int          STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_STORE = 3'b100
    } asq_state_e;

endpackage

// ---- design/asq_result_mem.sv ----
// result store: eight 8-bit words, one per channel, registered read
// assumes one writer (the sequencer) and one reader (the bus slave)
`timescale 1ns/1ns
`default_nettype none

module asq_result_mem (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic       re,
    input  wire logic [2:0] raddr,
    output logic      [7:0] rdata
);

    typedef struct packed {
        logic [7:0][7:0] word;
        logic [7:0]      rdata;
    } asq_mem_s;

    asq_mem_s mem_reg;
    asq_mem_s mem_next;

    // write port updates one word, read port samples one word
    always_comb begin
        mem_next = mem_reg;
        if (we) begin
            mem_next.word[waddr] = wdata;
        end
        if (re) begin
            mem_next.rdata = mem_reg.word[raddr]; // old value on same-cycle write
        end
    end

    // state register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_reg <= '0;
        end else begin
            mem_reg <= mem_next;
        end
    end

    assign rdata = mem_reg.rdata;

endmodule

`default_nettype wire

// ---- design/asq_top.sv ----
// scan sequencer of an 8-bit successive-approximation converter
// assumes a comparator answering within one tick and an AXI4-Lite master
//
// How it works
// - input at or above high reference yields code ff, no overflow flag.
// - input below low reference yields code 00.
// - processor wait state leaves the converter running.
// - halt blocks conversion until halt ends and start-up delay passes.
// - single channel single mode converts the named channel, flags end, waits.
// - multi channel single mode converts channels 0..last, flags end, waits.
// - single channel continuous mode reconverts the named channel.
// - multi channel continuous mode rescans channels 0..last.
// - bias enable resets to zero and is forced to zero while halted.
// - each channel result lands in its own register, indices 1..8.
// - last channel field bits 7..5 bounds the scan starting at channel 0.
// - last channel field zero converts only channel 0.
// - multi channel bit 3 picks one channel or the whole group.
// - bias bit 2 enables the converter; zero idles all converter logic.
// - continuous bit 1 keeps converting after the first sequence.
// - go bit 0 starts or stops; hardware clears it after single sequences.
// - every conversion lasts 82 converter clock ticks.
// - converter clock is master clock, halved when the halving bit is set.
// - end of conversion is an event for one maskable interrupt channel.
`timescale 1ns/1ns
`default_nettype none

module asq_top
    import asq_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = STARTUP_CYC
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // write address channel
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    // write data channel
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    // write response channel
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // read address channel
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    // read data channel
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // processor power states
    input  wire logic                  halt_in,
    input  wire logic                  wait_in,
    // analog front end
    input  wire logic                  cmp_above,
    output logic [2:0]                 mux_channel,
    output logic                       sample_hold,
    output logic [7:0]                 dac_code,
    output logic                       bias_enable,
    output logic                       eoc_pulse
);

    // ----------------------------------------------------------------
    // state record
    // ----------------------------------------------------------------
    typedef struct packed {
        asq_state_e      state;
        logic [7:0]      cfg;
        logic            div_ph;
        logic [6:0]      conv_cnt;
        logic [1:0]      sub;
        logic            sampling;
        logic [7:0]      dac;
        logic [7:0]      mask;
        logic [2:0]      chan;
        logic [12:0]     settle;
        logic            eoc;
        logic            awready;
        logic            wready;
        logic            bvalid;
        logic [1:0]      bresp;
        logic            aw_full;
        logic [3:0]      aw_idx;
        logic            w_full;
        logic [7:0]      w_byte;
        logic            w_lane;
        logic            arready;
        logic            rd_pend;
        logic [3:0]      ar_idx;
        logic            rvalid;
        logic [1:0]      rresp;
        logic [31:0]     rdata;
    } asq_regs_s;

    localparam asq_regs_s REGS_RESET = '{
        state:   ST_IDLE,
        cfg:     CFG_RESET,
        awready: 1'b1,
        wready:  1'b1,
        arready: 1'b1,
        default: '0
    };

    localparam logic [12:0] SETTLE_LOAD = 13'(STARTUP_CYCLES);

    asq_regs_s   s_reg;
    asq_regs_s   s_next;

    logic        tick;
    logic        run_ok;
    logic [2:0]  last_chan;
    logic [2:0]  first_chan;
    logic        seq_end;
    logic        mem_we;
    logic        mem_re;
    logic [3:0]  mem_ridx;
    logic [7:0]  mem_rdata;
    logic [7:0]  status_byte;

    // ----------------------------------------------------------------
    // derived control terms
    // ----------------------------------------------------------------

    // converter tick: every cycle, or every second cycle when halved
    assign tick = !s_reg.cfg[CFG_HALVE_BIT] || s_reg.div_ph;

    // conversions need go, bias, no halt and a finished settle count
    assign run_ok = s_reg.cfg[CFG_GO_BIT] && s_reg.cfg[CFG_BIAS_BIT]
                    && !halt_in && (s_reg.settle == 13'h0000);

    // wait_in gates nothing; status shows it
    assign last_chan  = s_reg.cfg[CFG_LAST_MSB:CFG_LAST_LSB];
    assign first_chan = s_reg.cfg[CFG_MULTI_BIT] ? 3'h0 : last_chan;

    // sequence ends on the last channel, or after one in single channel
    assign seq_end = !s_reg.cfg[CFG_MULTI_BIT] || (s_reg.chan == last_chan);

    // result write while storing, never when aborting
    assign mem_we = (s_reg.state == ST_STORE) && run_ok;

    // result read is launched at the address handshake
    assign mem_ridx = 4'(araddr[5:2] - IDX_RESULT_FIRST);
    assign mem_re   = arvalid && s_reg.arready;

    // status view of the sequencer
    always_comb begin
        status_byte                               = 8'h00;
        status_byte[STAT_BUSY_BIT]                = (s_reg.state != ST_IDLE);
        status_byte[STAT_CHAN_MSB:STAT_CHAN_LSB]  = s_reg.chan;
        status_byte[STAT_SETTLE_BIT]              = (s_reg.settle != 13'h0000);
        status_byte[STAT_WAIT_BIT]                = wait_in;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // sequencer, bus slave and halt handling
    always_comb begin
        s_next        = s_reg;
        s_next.eoc    = 1'b0;
        s_next.div_ph = (s_reg.state == ST_CONV) && !s_reg.div_ph;

        // sequencer
        unique case (s_reg.state)
            ST_IDLE: begin
                if (run_ok) begin
                    s_next.state    = ST_CONV;
                    s_next.chan     = first_chan;
                    s_next.conv_cnt = 7'h00;
                    s_next.sub      = 2'h0;
                    s_next.sampling = 1'b1;
                    s_next.dac      = 8'h00;
                    s_next.mask     = 8'h00;
                end
            end
            ST_CONV: begin
                if (!run_ok) begin
                    s_next.state    = ST_IDLE;
                    s_next.sampling = 1'b0;
                    s_next.dac      = 8'h00;
                    s_next.mask     = 8'h00;
                end else if (tick) begin
                    s_next.conv_cnt = 7'(s_reg.conv_cnt + 7'h01);
                    if (s_reg.conv_cnt == CONV_LAST) begin
                        s_next.state = ST_STORE;
                    end
                    if (s_reg.sampling) begin
                        if (s_reg.conv_cnt == SAMPLE_LAST) begin
                            s_next.sampling = 1'b0;
                            s_next.dac      = CODE_MSB;
                            s_next.mask     = CODE_MSB;
                            s_next.sub      = 2'h0;
                        end
                    end else if (s_reg.sub == BIT_LAST) begin
                        // keep the trial bit only if the input stands at or above it
                        s_next.sub  = 2'h0;
                        s_next.mask = s_reg.mask >> 1;
                        s_next.dac  = (cmp_above ? s_reg.dac : (s_reg.dac & ~s_reg.mask))
                                      | (s_reg.mask >> 1);
                    end else begin
                        s_next.sub = 2'(s_reg.sub + 2'h1);
                    end
                end
            end
            ST_STORE: begin
                s_next.conv_cnt = 7'h00;
                s_next.sub      = 2'h0;
                s_next.mask     = 8'h00;
                if (!run_ok) begin
                    s_next.state = ST_IDLE;
                    s_next.dac   = 8'h00;
                end else if (!seq_end) begin
                    s_next.state    = ST_CONV;
                    s_next.chan     = 3'(s_reg.chan + 3'h1);
                    s_next.sampling = 1'b1;
                end else begin
                    s_next.eoc = 1'b1;
                    if (s_reg.cfg[CFG_CONT_BIT]) begin
                        s_next.state    = ST_CONV;
                        s_next.chan     = first_chan;
                        s_next.sampling = 1'b1;
                    end else begin
                        s_next.state          = ST_IDLE;
                        s_next.cfg[CFG_GO_BIT] = 1'b0;
                    end
                end
            end
        endcase

        // write address and data are captured independently
        if (awvalid && s_reg.awready) begin
            s_next.aw_full = 1'b1;
            s_next.aw_idx  = awaddr[5:2];
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_full = 1'b1;
            s_next.w_byte = wdata[7:0];
            s_next.w_lane = wstrb[0];
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end

        // write takes effect once both halves are held; software wins over
        // the hardware clear of the go bit in the same cycle
        if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
            s_next.aw_full = 1'b0;
            s_next.w_full  = 1'b0;
            s_next.bvalid  = 1'b1;
            if (s_reg.aw_idx == IDX_CONTROL) begin
                s_next.bresp = RESP_OKAY;
                if (s_reg.w_lane) begin
                    s_next.cfg = s_reg.w_byte;
                end
            end else begin
                s_next.bresp = RESP_SLVERR; // results and status are read only
            end
        end
        s_next.awready = !s_next.aw_full && !s_next.bvalid;
        s_next.wready  = !s_next.w_full && !s_next.bvalid;

        // read address handshake, then one cycle for the result store
        if (mem_re) begin
            s_next.arready = 1'b0;
            s_next.rd_pend = 1'b1;
            s_next.ar_idx  = araddr[5:2];
        end
        if (s_reg.rd_pend) begin
            s_next.rd_pend = 1'b0;
            s_next.rvalid  = 1'b1;
            s_next.rresp   = RESP_OKAY;
            if (s_reg.ar_idx == IDX_CONTROL) begin
                s_next.rdata = {24'h000000, s_reg.cfg};
            end else if (s_reg.ar_idx == IDX_STATUS) begin
                s_next.rdata = {24'h000000, status_byte};
            end else if ((s_reg.ar_idx >= IDX_RESULT_FIRST) && (s_reg.ar_idx <= IDX_RESULT_LAST)) begin
                s_next.rdata = {24'h000000, mem_rdata};
            end else begin
                s_next.rdata = 32'h00000000;
                s_next.rresp = RESP_SLVERR;
            end
        end
        if (s_reg.rvalid && rready) begin
            s_next.rvalid  = 1'b0;
            s_next.arready = 1'b1;
        end

        // halt forces the bias off and restarts the settle count
        if (halt_in) begin
            s_next.cfg[CFG_BIAS_BIT] = 1'b0;
            s_next.settle            = SETTLE_LOAD;
        end else if (s_reg.settle != 13'h0000) begin
            s_next.settle = 13'(s_reg.settle - 13'h0001);
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------

    // synchronous reset to the idle record
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= REGS_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // result store
    // ----------------------------------------------------------------

    // one word per channel, written when its conversion completes
    asq_result_mem u_result_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (mem_we),
        .waddr   (s_reg.chan),
        .wdata   (s_reg.dac),
        .re      (mem_re),
        .raddr   (mem_ridx[2:0]),
        .rdata   (mem_rdata)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // every output is a field of the state record
    assign awready     = s_reg.awready;
    assign wready      = s_reg.wready;
    assign bvalid      = s_reg.bvalid;
    assign bresp       = s_reg.bresp;
    assign arready     = s_reg.arready;
    assign rvalid      = s_reg.rvalid;
    assign rresp       = s_reg.rresp;
    assign rdata       = s_reg.rdata;
    assign mux_channel = s_reg.chan;
    assign sample_hold = s_reg.sampling;
    assign dac_code    = s_reg.dac;
    assign bias_enable = s_reg.cfg[CFG_BIAS_BIT];
    assign eoc_pulse   = s_reg.eoc;

endmodule

`default_nettype wire

// ---- bench/asq_top_assertions.sv ----
// checker of the sequencer top: bus timing, halt and end of sequence
// assumes it is bound to asq_top and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none

module asq_top_checker
    import asq_pkg::*;
(
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       awvalid,
    input wire logic       awready,
    input wire logic       wvalid,
    input wire logic       wready,
    input wire logic       bvalid,
    input wire logic       arvalid,
    input wire logic       arready,
    input wire logic       rvalid,
    input wire logic       halt_in,
    input wire logic       sample_hold,
    input wire logic [7:0] dac_code,
    input wire logic       bias_enable,
    input wire logic       eoc_pulse
);
    logic [7:0] hold_len;

    // aclk cycles of the current sample phase
    always_ff @(posedge aclk) begin
        hold_len <= sample_hold ? hold_len + 8'h01 : 8'h00;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_eoc_single: assert property (eoc_pulse |=> !eoc_pulse)
        else $error("end pulse too long");
    chk_bias_halt: assert property (halt_in [*2] |=> !bias_enable)
        else $error("bias on while halted");
    chk_halt_idle: assert property (halt_in [*2] |=> !sample_hold && !eoc_pulse)
        else $error("converter active while halted");
    chk_settle_wait: assert property ($fell(halt_in) |-> !sample_hold [*8])
        else $error("conversion before start-up delay");
    chk_sample_len: assert property ($fell(sample_hold) && dac_code == CODE_MSB |->
        hold_len == 8'(SAMPLE_TICKS) || hold_len == 8'(2 * SAMPLE_TICKS))
        else $error("bad sample phase length");
    chk_bias_idle: assert property (!bias_enable [*2] |=> !sample_hold)
        else $error("sampling with bias off");
    chk_read_lat: assert property (arvalid && arready |-> ##2 rvalid)
        else $error("read answer late");
    chk_write_lat: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    chk_ar_block: assert property (arvalid && arready |=> !arready)
        else $error("second read accepted");
endmodule

bind asq_top asq_top_checker u_asq_top_checker (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .halt_in(halt_in), .sample_hold(sample_hold), .dac_code(dac_code),
    .bias_enable(bias_enable), .eoc_pulse(eoc_pulse)
);

`default_nettype wire

// ---- bench/asq_front_end.sv ----
// model of the analog mux, sample-and-hold and comparator
// assumes levels holds one byte per channel, channel 0 lowest
`timescale 1ns/1ns
`default_nettype none

module asq_front_end (
    input  wire logic        aclk,
    input  wire logic [2:0]  mux_channel,
    input  wire logic        sample_hold,
    input  wire logic [7:0]  dac_code,
    input  wire logic [63:0] levels,
    output logic             cmp_above
);
    logic [7:0] held = 8'h00;

    // track the selected input while sampling, then hold
    always_ff @(posedge aclk) begin
        if (sample_hold) begin
            held <= levels[mux_channel * 8 +: 8];
        end
    end

    // high when the held input is at or above the trial code
    assign cmp_above = held >= dac_code;
endmodule

`default_nettype wire

// ---- bench/adc_scan_sequencer_bench.sv ----
// self-checking bench of the scan sequencer, driven over its register bus
// assumes asq_top, its bound checker and the model asq_front_end
`timescale 1ns/1ns
`default_nettype none

module adc_scan_sequencer_bench import asq_pkg::*;;
    localparam int         STARTUP = 20;
    // rows: control value and input base level
    localparam logic [7:0] ROW_CFG [5]  = '{8'h65, 8'h6d, 8'h0d, 8'h15, 8'hed};
    localparam logic [7:0] ROW_BASE [5] = '{8'h5a, 8'h3c, 8'hff, 8'h00, 8'h96};
    localparam logic [7:0] CONT_CFG [2] = '{8'h67, 8'h2f};
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, halt_in = 1'b0, wait_in = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, cmp_above, sample_hold, bias_enable, eoc_pulse;
    logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
    logic [3:0]  wstrb = 4'h1;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  mux_channel;
    logic [7:0]  dac_code;
    logic [63:0] levels = 64'h0;
    logic [7:0]  exp_res [8] = '{default: 8'h00};
    int          err_count = 0, checked = 0;

    always #(CLK_PERIOD_NS / 2) aclk = ~aclk;

    asq_top #(.STARTUP_CYCLES(STARTUP)) u_asq_top (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .halt_in(halt_in), .wait_in(wait_in),
        .cmp_above(cmp_above), .mux_channel(mux_channel), .sample_hold(sample_hold),
        .dac_code(dac_code), .bias_enable(bias_enable), .eoc_pulse(eoc_pulse));
    asq_front_end u_asq_front_end (.aclk(aclk), .mux_channel(mux_channel), .sample_hold(sample_hold),
        .dac_code(dac_code), .levels(levels), .cmp_above(cmp_above));

    // level of channel i for base b
    function automatic logic [7:0] lvl(input logic [7:0] b, input int i);
        return b ^ 8'(i << 4);
    endfunction
    // channels one sequence of control c converts
    function automatic bit in_set(input logic [7:0] c, input int i);
        return c[3] ? i <= int'(c[7:5]) : i == int'(c[7:5]);
    endfunction
    task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus write: both halves offered, each released when taken
    task automatic bus_wr(input logic [5:0] a, input logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (bvalid !== 1'b1) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic bus_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rvalid !== 1'b1) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        bus_rd(a, d, r);
        check($sformatf("reg at %h", a), {RESP_OKAY, e}, {r, d});
    endtask
    task automatic check_results();
        for (int i = 0; i < 8; i++) rd_chk(6'((i + 1) * 4), 32'(exp_res[i]));
    endtask
    task automatic set_levels(input logic [7:0] b);
        for (int i = 0; i < 8; i++) levels[i * 8 +: 8] <= lvl(b, i);
    endtask
    task automatic wait_eoc(input int lim, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < lim && !seen; n++) begin
            @(posedge aclk);
            seen = (eoc_pulse === 1'b1);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        tally_and_finish();
    end

    // reset, table rows, bus error cases, then stop and halt cases
    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        logic        seen;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("bias after reset", 34'h0, 34'(bias_enable));
        rd_chk(6'h00, 32'h0);
        bus_wr(6'h00, 8'h04, r);
        repeat (STARTUP) @(posedge aclk);
        wait_in <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            set_levels(ROW_BASE[k]);
            bus_wr(6'h00, ROW_CFG[k], r);
            wait_eoc(900, seen);
            check("end of sequence", 34'h1, 34'(seen));
            for (int i = 0; i < 8; i++) if (in_set(ROW_CFG[k], i)) exp_res[i] = lvl(ROW_BASE[k], i);
            rd_chk(6'h00, 32'(ROW_CFG[k] & 8'hfe));
            check_results();
        end
        bus_wr(6'h08, 8'h55, r);
        check("result write resp", 34'(RESP_SLVERR), 34'(r));
        bus_rd(6'h28, d, r);
        check("unmapped read", {RESP_SLVERR, 32'h0}, {r, d});
        for (int k = 0; k < 2; k++) begin
            set_levels(8'h21);
            bus_wr(6'h00, CONT_CFG[k], r);
            wait_eoc(900, seen);
            set_levels(8'hc3);
            wait_eoc(900, seen);
            check("repeated end", 34'h1, 34'(seen));
            for (int i = 0; i < 8; i++) if (in_set(CONT_CFG[k], i)) exp_res[i] = lvl(8'hc3, i);
            repeat (30) @(posedge aclk);
            set_levels(8'h77);
            bus_wr(6'h00, CONT_CFG[k] & 8'hfe, r);
            wait_eoc(300, seen);
            check("end after stop", 34'h0, 34'(seen));
            check_results();
        end
        set_levels(8'h42);
        bus_wr(6'h00, 8'h65, r);
        repeat (30) @(posedge aclk);
        halt_in <= 1'b1;
        wait_eoc(200, seen);
        check("end while halted", 34'h0, 34'(seen));
        bus_rd(6'h00, d, r);
        check("bias while halted", 34'h0, 34'(d[2]));
        halt_in <= 1'b0;
        bus_wr(6'h00, 8'h65, r);
        wait_eoc(400, seen);
        check("end after halt", 34'h1, 34'(seen));
        exp_res[3] = lvl(8'h42, 3);
        check_results();
        tally_and_finish();
    end
endmodule

`default_nettype wire
